// File: smbw_pkg.sv
// Shared constants for the SMBus block-write link
package smbw_pkg;
  localparam logic [6:0] TARGET_ADDR = 7'h6a;
  localparam logic DIR_WRITE = 1'b0;
  localparam int NUM_REGS = 8;
  localparam int IDX_W = 3;
  localparam int SCL_HALF = 63;
  localparam logic [6:0] SCL_HALF_CNT = 7'h3e;
  localparam int REF_TIMEOUT = 32;
  localparam logic [5:0] REF_TIMEOUT_CNT = 6'h1f;
endpackage : smbw_pkg

// File: smbw_if.sv
// Two-wire link between host and target
`timescale 1ns/1ps
interface smbw_if;
  logic scl_o;
  logic scl_oe;
  logic sda_host_o;
  logic sda_host_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic scl;
  logic sda;
  assign scl = scl_oe ? scl_o : 1'b1;
  assign sda = (sda_host_oe && !sda_host_o) || (sda_dev_oe && !sda_dev_o) ? 1'b0 : 1'b1;
  modport host (output scl_o, output scl_oe, output sda_host_o, output sda_host_oe,
    input scl, input sda);
  modport device (output sda_dev_o, output sda_dev_oe, input scl, input sda);
endinterface : smbw_if

// File: smbw_target.sv
// Target end: SMBus block write into a register bank
// Summary of operation
// RULE1 - Host opens each write with start
// RULE2 - Device acknowledges its own write address
// RULE3 - Index byte acknowledged, first written location
// RULE4 - Count byte acknowledged by device
// RULE5 - Data stored consecutively from index N
// RULE6 - Every data byte acknowledged individually
// RULE7 - Host ends write with stop
// RULE8 - Target idle unless reference clock runs
// RULE9 - Address is seven bits plus direction
`timescale 1ns/1ps
module smbw_target (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // Reference clock presence
  input wire logic ref_clk,
  // Link
  smbw_if.device bus,
  // Register bank
  output logic [8*smbw_pkg::NUM_REGS-1:0] regs,
  // Status
  output logic busy,
  output logic wr_pulse
);
  // One-hot receiver states
  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_ADDR = 6'h02,
    S_IDX = 6'h04,
    S_CNT = 6'h08,
    S_DATA = 6'h10,
    S_IGN = 6'h20
  } st_t;
  // All registered state
  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic [1:0] ref_s;
    logic scl_d;
    logic sda_d;
    logic ref_d;
    logic [5:0] ref_cnt;
    logic ref_ok;
    st_t st;
    logic [3:0] bitc;
    logic [7:0] sh;
    logic acking;
    logic [7:0] idx;
    logic [7:0] cnt;
    logic [8*smbw_pkg::NUM_REGS-1:0] regs;
    logic sda_oe;
    logic wr;
    logic busy;
  } state_t;
  state_t r_reg;
  state_t r_next;
  // Synchronised pins and their events
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic last;

  // Own address with the write direction
  function automatic logic addr_hit(input logic [7:0] b);
    return b[7:1] == smbw_pkg::TARGET_ADDR && b[0] == smbw_pkg::DIR_WRITE;
  endfunction : addr_hit

  // States in which bits are shifted in
  function automatic logic shifting(input st_t s);
    return s != S_IDLE && s != S_IGN;
  endfunction : shifting

  // Index inside the register bank
  function automatic logic lane_ok(input logic [7:0] i);
    return i < 8'(smbw_pkg::NUM_REGS);
  endfunction : lane_ok

  always_comb begin
    r_next = r_reg;
    // Input synchronisers
    r_next.scl_s = {r_reg.scl_s[0], bus.scl};
    r_next.sda_s = {r_reg.sda_s[0], bus.sda};
    r_next.ref_s = {r_reg.ref_s[0], ref_clk};
    r_next.scl_d = r_reg.scl_s[1];
    r_next.sda_d = r_reg.sda_s[1];
    r_next.ref_d = r_reg.ref_s[1];
    r_next.wr = 1'b0;
    // Edges and bus conditions
    scl = r_reg.scl_s[1];
    sda = r_reg.sda_s[1];
    scl_rise = scl && !r_reg.scl_d;
    scl_fall = !scl && r_reg.scl_d;
    start_c = scl && r_reg.scl_d && r_reg.sda_d && !sda;
    stop_c = scl && r_reg.scl_d && !r_reg.sda_d && sda;
    last = 1'b0;

    // Reference clock watchdog
    if (r_reg.ref_s[1] != r_reg.ref_d) begin
      r_next.ref_cnt = 6'h00;
      r_next.ref_ok = 1'b1;
    end else if (r_reg.ref_cnt == smbw_pkg::REF_TIMEOUT_CNT) begin
      r_next.ref_ok = 1'b0; // RULE8
    end else begin
      r_next.ref_cnt = r_reg.ref_cnt + 6'h01;
    end

    // Frame receiver
    if (!r_reg.ref_ok) begin
      r_next.st = S_IDLE; // RULE8
      r_next.sda_oe = 1'b0;
    end else if (stop_c) begin
      r_next.st = S_IDLE; // RULE7
      r_next.sda_oe = 1'b0;
    end else if (start_c) begin
      r_next.st = S_ADDR; // RULE1
      r_next.bitc = 4'h0;
      r_next.acking = 1'b0;
      r_next.sda_oe = 1'b0;
    end else if (scl_rise && !r_reg.acking && shifting(r_reg.st)) begin
      r_next.sh = {r_reg.sh[6:0], sda};
      r_next.bitc = r_reg.bitc + 4'h1;
    end else if (scl_fall) begin
      if (r_reg.acking) begin
        // Ack bit over: release the data line
        r_next.acking = 1'b0;
        r_next.sda_oe = 1'b0;
        r_next.bitc = 4'h0;
      end else if (r_reg.bitc == 4'h8) begin
        // Byte complete: acknowledge, then decode
        r_next.acking = 1'b1;
        r_next.sda_oe = 1'b1; // RULE6
        case (r_reg.st)
          S_ADDR: begin
            if (addr_hit(r_reg.sh)) begin
              r_next.st = S_IDX; // RULE2 RULE9
            end else begin
              r_next.st = S_IGN;
              r_next.sda_oe = 1'b0;
              r_next.acking = 1'b0;
            end
          end
          S_IDX: begin
            r_next.idx = r_reg.sh; // RULE3
            r_next.st = S_CNT;
          end
          S_CNT: begin
            r_next.cnt = r_reg.sh; // RULE4
            // Zero count: acknowledge, store nothing
            if (r_reg.sh == 8'h00) begin
              r_next.st = S_IGN;
            end else begin
              r_next.st = S_DATA;
            end
          end
          S_DATA: begin
            if (lane_ok(r_reg.idx)) begin
              r_next.regs[r_reg.idx[smbw_pkg::IDX_W-1:0]*8 +: 8] = r_reg.sh; // RULE5
              r_next.wr = 1'b1;
            end
            r_next.idx = r_reg.idx + 8'h01; // RULE5
            r_next.cnt = r_reg.cnt - 8'h01;
            last = (r_reg.cnt == 8'h01);
            if (last) begin
              r_next.st = S_IGN; // RULE6
            end
          end
          default: begin
            r_next.st = S_IGN;
            r_next.sda_oe = 1'b0;
            r_next.acking = 1'b0;
          end
        endcase
      end
    end

    // Busy follows the next state
    r_next.busy = (r_next.st != S_IDLE);
  end

  // Registered state, frozen while ce is low
  always_ff @(posedge clk) begin
    if (!resetn) begin
      r_reg <= '0;
      r_reg.scl_s <= 2'h3;
      r_reg.sda_s <= 2'h3;
      r_reg.scl_d <= 1'b1;
      r_reg.sda_d <= 1'b1;
      r_reg.st <= S_IDLE;
      r_reg.regs <= '0;
      r_reg.ref_ok <= 1'b0; // RULE8
      r_reg.busy <= 1'b0;
      r_reg.sda_oe <= 1'b0;
    end else if (ce) begin
      r_reg <= r_next;
    end
  end

  // Ack drives low
  assign bus.sda_dev_o = 1'b0;
  assign bus.sda_dev_oe = r_reg.sda_oe; // RULE6
  assign regs = r_reg.regs;
  assign busy = r_reg.busy;
  assign wr_pulse = r_reg.wr;
endmodule : smbw_target

// File: smbw_host.sv
// Host end: issues one SMBus block write per request
`timescale 1ns/1ps
module smbw_host (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // Request
  input wire logic go,
  input wire logic [7:0] addr_byte,
  input wire logic [7:0] start_idx,
  input wire logic [7:0] count,
  input wire logic [8*smbw_pkg::NUM_REGS-1:0] data,
  // Status
  output logic busy,
  output logic done,
  output logic nack,
  // Link
  smbw_if.host bus
);
  typedef enum logic [4:0] {
    H_IDLE = 5'h01, H_START = 5'h02, H_BITS = 5'h04, H_ACK = 5'h08, H_STOP = 5'h10
  } hst_t;
  typedef struct packed {
    logic [1:0] sda_s;
    hst_t st;
    logic [6:0] tick;
    logic [1:0] ph;
    logic [3:0] bitc;
    logic [7:0] sh;
    logic [7:0] nbytes;
    logic [7:0] sent;
    logic [8*smbw_pkg::NUM_REGS-1:0] buf_d;
    logic [7:0] cnt;
    logic scl;
    logic sda;
    logic scl_oe;
    logic sda_oe;
    logic busy;
    logic done;
    logic nack;
  } hstate_t;
  hstate_t r_reg, r_next;
  logic adv;

  always_comb begin
    r_next = r_reg;
    r_next.sda_s = {r_reg.sda_s[0], bus.sda};
    r_next.done = 1'b0;
    adv = (r_reg.tick == smbw_pkg::SCL_HALF_CNT);
    r_next.tick = adv ? 7'h00 : r_reg.tick + 7'h01;
    case (r_reg.st)
      H_IDLE: begin
        r_next.tick = 7'h00;
        if (go) begin
          r_next.st = H_START;
          r_next.busy = 1'b1;
          r_next.nack = 1'b0;
          r_next.sh = addr_byte; // RULE2
          r_next.nbytes = count + 8'h03;
          r_next.sent = 8'h00;
          r_next.cnt = count;
          r_next.buf_d = data;
          r_next.ph = 2'h0;
        end
      end
      H_START: begin
        if (adv) begin
          r_next.sda = 1'b0; // RULE1
          r_next.st = H_BITS;
          r_next.bitc = 4'h0;
          r_next.ph = 2'h0;
        end
      end
      H_BITS: begin
        if (adv) begin
          r_next.ph = r_reg.ph + 2'h1;
          if (r_reg.ph == 2'h0) begin
            r_next.scl = 1'b0;
          end else if (r_reg.ph == 2'h1) begin
            r_next.sda = r_reg.sh[7];
          end else if (r_reg.ph == 2'h2) begin
            r_next.scl = 1'b1;
          end else begin
            r_next.sh = {r_reg.sh[6:0], 1'b0};
            r_next.bitc = r_reg.bitc + 4'h1;
            r_next.ph = 2'h0;
            if (r_reg.bitc == 4'h7) begin
              r_next.st = H_ACK;
            end
          end
        end
      end
      H_ACK: begin
        if (adv) begin
          r_next.ph = r_reg.ph + 2'h1;
          if (r_reg.ph == 2'h0) begin
            r_next.scl = 1'b0;
          end else if (r_reg.ph == 2'h1) begin
            r_next.sda = 1'b1;
          end else if (r_reg.ph == 2'h2) begin
            r_next.scl = 1'b1;
          end else begin
            r_next.ph = 2'h0;
            r_next.sent = r_reg.sent + 8'h01;
            r_next.bitc = 4'h0;
            if (r_reg.sda_s[1]) begin
              r_next.nack = 1'b1;
              r_next.st = H_STOP;
            end else if (r_reg.sent + 8'h01 == r_reg.nbytes) begin
              r_next.st = H_STOP; // RULE7
            end else begin
              r_next.st = H_BITS;
              if (r_reg.sent == 8'h00) begin
                r_next.sh = start_idx; // RULE3
              end else if (r_reg.sent == 8'h01) begin
                r_next.sh = r_reg.cnt; // RULE4
              end else begin
                r_next.sh = r_reg.buf_d[7:0]; // RULE5
                r_next.buf_d = r_reg.buf_d >> 8;
              end
            end
          end
        end
      end
      H_STOP: begin
        if (adv) begin
          r_next.ph = r_reg.ph + 2'h1;
          if (r_reg.ph == 2'h0) begin
            r_next.scl = 1'b0;
          end else if (r_reg.ph == 2'h1) begin
            r_next.sda = 1'b0;
          end else if (r_reg.ph == 2'h2) begin
            r_next.scl = 1'b1;
          end else begin
            r_next.sda = 1'b1; // RULE7
            r_next.st = H_IDLE;
            r_next.busy = 1'b0;
            r_next.done = 1'b1;
            r_next.ph = 2'h0;
          end
        end
      end
      default: r_next.st = H_IDLE;
    endcase
    // Open-drain enables from the next line levels
    r_next.scl_oe = !r_next.scl;
    r_next.sda_oe = !r_next.sda;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      r_reg <= '0;
      r_reg.sda_s <= 2'h3;
      r_reg.st <= H_IDLE;
      r_reg.scl <= 1'b1;
      r_reg.sda <= 1'b1;
    end else if (ce) begin
      r_reg <= r_next;
    end
  end

  // Open drain: drive only lows
  assign bus.scl_o = 1'b0;
  assign bus.scl_oe = r_reg.scl_oe;
  assign bus.sda_host_o = 1'b0;
  assign bus.sda_host_oe = r_reg.sda_oe;
  assign busy = r_reg.busy;
  assign done = r_reg.done;
  assign nack = r_reg.nack;
endmodule : smbw_host

// File: smbw_asserts.sv
// Concurrent checks on the block-write link
`timescale 1ns/1ps
module smbw_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Link
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_dev_oe,
  input wire logic ref_clk,
  // Status
  input wire logic t_busy,
  input wire logic wr_pulse,
  input wire logic h_busy,
  input wire logic done
);
  logic ref_q_reg;
  logic [6:0] ref_cnt_reg;
  // Cycles since the reference clock last changed
  always_ff @(posedge clk) begin
    ref_q_reg <= ref_clk;
    if (!resetn || ref_clk != ref_q_reg) begin
      ref_cnt_reg <= 7'h00;
    end else if (ref_cnt_reg != 7'h7f) begin
      ref_cnt_reg <= ref_cnt_reg + 7'h01;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  AST_HOST_START: assert property ($rose(h_busy) |-> ##[61:65] (scl && !sda))
    else $error("no start after request");
  AST_ACK_IN_LOW: assert property ($rose(sda_dev_oe) |-> !scl)
    else $error("ack began with clock high");
  AST_ACK_HOLD: assert property ($rose(sda_dev_oe) |=> sda_dev_oe [*8])
    else $error("ack released early");
  AST_ACK_BUSY: assert property (sda_dev_oe |-> t_busy)
    else $error("ack outside a transfer");
  AST_WR_BUSY: assert property (wr_pulse |-> t_busy)
    else $error("store outside a transfer");
  AST_WR_ONCE: assert property (wr_pulse |=> !wr_pulse)
    else $error("store pulse too long");
  AST_REF_IDLE: assert property (ref_cnt_reg > 7'h30 |-> !sda_dev_oe && !t_busy)
    else $error("target active without reference");
  AST_DONE_IDLE: assert property (done |-> scl && sda && !sda_dev_oe)
    else $error("link not released at done");
  AST_DONE_ONCE: assert property (done |=> !done)
    else $error("done pulse too long");
endmodule : smbw_asserts

// File: tb_top.sv
// Self-checking bench joining host and target ends
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic ref_clk = 1'b0;
  logic ref_run = 1'b1;
  logic go = 1'b0;
  logic [7:0] addr_byte = 8'h00;
  logic [7:0] start_idx = 8'h00;
  logic [7:0] count = 8'h00;
  logic [8*smbw_pkg::NUM_REGS-1:0] data = '0;
  logic [8*smbw_pkg::NUM_REGS-1:0] regs;
  logic h_busy, done, nack, t_busy, wr_pulse;
  logic [8:0] bit_sh = 9'h000;
  int n_fail = 0;
  int check_count = 0;
  int cycles = 0;
  int scl_rises = 0;
  int wr_seen = 0;
  smbw_if bus ();
  smbw_target u_smbw_target (.clk(clk), .resetn(resetn), .ce(1'b1), .ref_clk(ref_clk),
    .bus(bus), .regs(regs), .busy(t_busy), .wr_pulse(wr_pulse));
  smbw_host u_smbw_host (.clk(clk), .resetn(resetn), .ce(1'b1), .go(go), .addr_byte(addr_byte),
    .start_idx(start_idx), .count(count), .data(data), .busy(h_busy), .done(done),
    .nack(nack), .bus(bus));
  smbw_asserts u_smbw_asserts (.clk(clk), .resetn(resetn), .scl(bus.scl), .sda(bus.sda),
    .sda_dev_oe(bus.sda_dev_oe), .ref_clk(ref_clk), .t_busy(t_busy), .wr_pulse(wr_pulse),
    .h_busy(h_busy), .done(done));
  always #5 clk = ~clk;
  always #62.5 ref_clk = ref_run ? ~ref_clk : ref_clk;
  // Wire monitor: clock rises and last sampled bits
  always @(posedge bus.scl) begin
    scl_rises++;
    bit_sh = {bit_sh[7:0], bus.sda};
  end
  always @(posedge clk) begin
    if (wr_pulse === 1'b1) wr_seen++;
    cycles++;
    if (cycles == 80000) begin
      n_fail++;
      conclude();
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      $display("wrong value at %0t: %s", $time, msg);
      n_fail++;
    end
  endtask : chk
  task automatic xfer(input logic [7:0] a, input logic [7:0] i, input logic [7:0] c,
    input logic [63:0] d);
    int k;
    scl_rises = 0;
    wr_seen = 0;
    @(posedge clk);
    addr_byte <= a;
    start_idx <= i;
    count <= c;
    data <= d;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (k = 0; k < 40000; k++) begin
      @(posedge clk);
      #1;
      if (done === 1'b1) break;
    end
    chk(done, 1'b1, "no done");
  endtask : xfer
  task automatic t_block();
    xfer(8'hd4, 8'h01, 8'h03, 64'h332211);
    chk(regs, 64'h33221100, "block data");
    chk(nack, 1'b0, "block refused");
    chk(wr_seen, 3, "store count");
    chk(scl_rises, 55, "clock count");
    chk(bit_sh, {7'h33, 2'b00}, "bit order and ack");
    chk({bus.scl, bus.sda}, 2'b11, "idle level");
    repeat (8) @(posedge clk);
    #1;
    chk(t_busy, 1'b0, "target busy after stop");
    $display("t_block finished");
  endtask : t_block
  task automatic t_edge();
    xfer(8'hd4, 8'h06, 8'h02, 64'h5544);
    chk(regs, 64'h5544000033221100, "top bytes");
    chk(wr_seen, 2, "top store count");
    $display("t_edge finished");
  endtask : t_edge
  task automatic t_refuse();
    logic [7:0] bad [2];
    bad = '{8'hd5, 8'hd6};
    foreach (bad[j]) begin
      xfer(bad[j], 8'h00, 8'h01, 64'hff);
      chk(nack, 1'b1, "foreign address acked");
      chk(regs, 64'h5544000033221100, "foreign write stored");
    end
    $display("t_refuse finished");
  endtask : t_refuse
  task automatic t_ref_stall();
    ref_run = 1'b0;
    repeat (50) @(posedge clk);
    xfer(8'hd4, 8'h00, 8'h01, 64'hff);
    chk(nack, 1'b1, "acked without reference");
    chk(regs, 64'h5544000033221100, "stored without reference");
    ref_run = 1'b1;
    repeat (50) @(posedge clk);
    xfer(8'hd4, 8'h00, 8'h01, 64'h77);
    chk(regs, 64'h5544000033221177, "no recovery");
    $display("t_ref_stall finished");
  endtask : t_ref_stall
  task automatic conclude();
    $display("checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude
  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_block();
    t_edge();
    t_refuse();
    t_ref_stall();
    conclude();
  end
endmodule : tb_top
